/* File: rtl/tps_pkg.sv */
// Package of the travel profile sequencer: register map, field layout, timing constants.
// Assumes a 50 MHz system clock and a single AHB-Lite slave port.
package tps_pkg;

    // ==========================================================
    // Profile store
    localparam int          NUM_PROFILES  = 7;
    // Position gives up its top bit so that a profile still fits one bus word.
    localparam int          POS_W         = 15;
    localparam int          SPEED_W       = 7;
    localparam int          DWELL_W       = 7;
    localparam logic [6:0]  SPEED_MAX     = 7'h64;
    localparam logic [6:0]  DWELL_MAX     = 7'h64;

    // ==========================================================
    // Timing
    localparam int          CLK_HZ        = 50000000;
    localparam int          DWELL_STEP_MS = 100;
    localparam int          TICK_CYCLES   = CLK_HZ / 1000 * DWELL_STEP_MS;
    // Arrival is ignored this long after a move starts, so a stale at-target level is not taken.
    localparam int          ARRIVE_BLANK  = 6;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_SELECT   = 8'h08;
    localparam logic [7:0]  ADDR_PROF0    = 8'h10;
    localparam logic [7:0]  ADDR_PROF_END = 8'h28;

    // Control register bits.
    localparam int          CTRL_DIRECT   = 0;
    localparam int          CTRL_START    = 1;
    localparam int          CTRL_STOP     = 2;
    localparam int          CTRL_FRONT    = 3;
    localparam int          CTRL_FIELDBUS = 4;

    // Profile register layout.
    localparam int          PF_POS_LSB    = 0;
    localparam int          PF_SPD_LSB    = 15;
    localparam int          PF_DWL_LSB    = 22;
    localparam int          PF_REACHED    = 30;
    localparam int          PF_HOLD       = 31;
    localparam int          PF_SEQEND     = 29;

    localparam logic [31:0] PROF_RESET    = 32'h0000_0000;
    localparam logic [2:0]  SEL_RESET     = 3'h1;

    typedef struct packed {
        logic               hold;
        logic               reached;
        logic               seqEnd;
        logic [DWELL_W-1:0] dwell;
        logic [SPEED_W-1:0] speed;
        logic [POS_W-1:0]   pos;
    } tps_profile_s;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_MOVE  = 4'b0010,
        ST_DWELL = 4'b0100,
        ST_HOLD  = 4'b1000
    } tps_state_e;

endpackage

/* File: rtl/tps_sync.sv */
// Two-flop synchroniser for one asynchronous level.
// Assumes the destination clock is clk.
`timescale 1ns/1ps
`default_nettype none
module tps_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Data
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic meta_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q  <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/tps_dwell.sv */
// Dwell timer: counts 0.1 s ticks down from a loaded value.
// Assumes clkEn gates all state and load is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module tps_dwell
    import tps_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               clkEn,
    // Control
    input  wire logic               load,
    input  wire logic               run,
    input  wire logic [DWELL_W-1:0] dwell,
    output logic                    done
);
    logic [31:0]        tick_q;
    logic [DWELL_W-1:0] left_q;
    wire                tickWrap = (tick_q == 32'(TICK - 1));

    // ==========================================================
    // Counting
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_q <= '0;
            left_q <= '0;
        end else if (clkEn) begin
            if (load) begin
                tick_q <= '0;
                left_q <= dwell;
            end else if (run && left_q != '0) begin
                tick_q <= tickWrap ? '0 : tick_q + 32'd1;
                if (tickWrap) begin
                    left_q <= left_q - DWELL_W'(1);
                end
            end
        end
    end

    assign done = run && !load && (left_q == '0);
endmodule
`default_nettype wire

/* File: rtl/tps_top.sv */
// Travel profile sequencer: seven stored profiles stepped in turn, AHB-Lite register access.
// Assumes the position loop reports arrival on atTarget (a pin, synchronised here).
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tps_top
    import tps_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              clkEn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Profile selection from digital inputs
    input  wire logic [2:0]        dinSelect,
    input  wire logic              dinSelStrobe,
    // Position loop
    input  wire logic              atTarget,
    output logic [POS_W-1:0]       targetPos,
    output logic [SPEED_W-1:0]     currentCap,
    output logic                   driveEnable,
    output logic                   solenoidEnable,
    output logic                   inPosition
);
    // ==========================================================
    // Pin synchronisers
    logic       atTargetS;
    logic       strobeS;
    logic [2:0] dinS;

    tps_sync uSyncTgt (.clk(clk), .rst_b(rst_b), .asyncIn(atTarget), .syncOut(atTargetS));
    tps_sync uSyncStb (.clk(clk), .rst_b(rst_b), .asyncIn(dinSelStrobe), .syncOut(strobeS));

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gSel
            tps_sync uSyncSel (.clk(clk), .rst_b(rst_b), .asyncIn(dinSelect[g]),
                               .syncOut(dinS[g]));
        end
    endgenerate

    // ==========================================================
    // AHB-Lite address phase capture
    logic        wrPend_q;
    logic        rdPend_q;
    logic [7:0]  addr_q;
    logic        strobeD_q;

    wire  accept   = hsel && hready && htrans[1];
    wire  busWr    = wrPend_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q   <= '0;
        end else if (clkEn) begin
            wrPend_q <= accept && hwrite;
            rdPend_q <= accept && !hwrite;
            if (accept) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    function automatic logic isProf(input logic [7:0] a);
        return (a >= ADDR_PROF0) && (a <= ADDR_PROF_END) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [2:0] profIdx(input logic [7:0] a);
        logic [7:0] off;
        off = a - ADDR_PROF0;
        return off[4:2];
    endfunction

    // ==========================================================
    // Profile store
    tps_profile_s prof_q [NUM_PROFILES];
    logic [2:0]   sel_q;
    logic         direct_q;
    logic         front_q;
    logic         fieldbus_q;

    wire  wrProf   = busWr && isProf(addr_q);
    wire  [2:0] wIdx = profIdx(addr_q);
    wire  wrCtrl   = busWr && (addr_q == ADDR_CTRL);
    wire  wrSel    = busWr && (addr_q == ADDR_SELECT);
    wire  [2:0] wSel = hwdata[2:0];
    wire  selValid = (wSel != 3'h0);
    wire  directOn = wrCtrl && hwdata[CTRL_DIRECT] && !direct_q;
    wire  startCmd = wrCtrl && hwdata[CTRL_START];
    wire  stopCmd  = wrCtrl && hwdata[CTRL_STOP];
    // Fieldbus builds accept selections only from direct control or digital inputs.
    wire  busSel   = wrSel && selValid && (!fieldbus_q || direct_q);
    wire  dinSel   = strobeS && !strobeD_q && (dinS != 3'h0);
    wire  newSel   = busSel || dinSel;
    wire  [2:0] newIdx = busSel ? wSel : dinS;

    generate
        for (g = 0; g < NUM_PROFILES; g++) begin : gProf
            logic [SPEED_W-1:0] spd;
            logic [DWELL_W-1:0] dwl;
            // Out-of-range entries clip so the stored value stays a legal setting.
            assign spd = (hwdata[PF_SPD_LSB +: SPEED_W] > SPEED_MAX) ? SPEED_MAX
                       : hwdata[PF_SPD_LSB +: SPEED_W];
            assign dwl = (hwdata[PF_DWL_LSB +: DWELL_W] > DWELL_MAX) ? DWELL_MAX
                       : hwdata[PF_DWL_LSB +: DWELL_W];
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    prof_q[g] <= tps_profile_s'(PROF_RESET);
                end else if (clkEn && wrProf && wIdx == 3'(g)) begin
                    prof_q[g].pos     <= hwdata[PF_POS_LSB +: POS_W];
                    prof_q[g].speed   <= spd;
                    prof_q[g].dwell   <= dwl;
                    prof_q[g].seqEnd  <= hwdata[PF_SEQEND];
                    prof_q[g].reached <= hwdata[PF_REACHED];
                    prof_q[g].hold    <= hwdata[PF_HOLD];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Sequencer
    tps_state_e   state_q;
    tps_state_e   state_d;
    logic [2:0]   cur_q;
    logic [2:0]   cur_d;
    tps_profile_s act_q;
    logic         running_q;
    logic         running_d;
    logic         dwellLoad;
    logic         dwellDone;
    logic [2:0]   blank_q;

    wire  [2:0]   nextIdx = (cur_q == 3'(NUM_PROFILES)) ? 3'h1 : cur_q + 3'h1;
    tps_profile_s curProf;
    assign curProf = prof_q[cur_q - 3'h1];

    always_comb begin
        state_d   = state_q;
        cur_d     = cur_q;
        running_d = running_q;
        dwellLoad = 1'b0;
        if (directOn) begin
            running_d = hwdata[CTRL_FRONT];
        end else if (startCmd) begin
            running_d = 1'b1;
        end
        if (stopCmd) begin
            running_d = 1'b0;
        end
        if (newSel) begin
            cur_d = newIdx;
        end
        case (state_q)
            ST_IDLE: begin
                if (running_d) begin
                    state_d = ST_MOVE;
                end
            end
            ST_MOVE: begin
                if (!running_d) begin
                    state_d = ST_IDLE;
                end else if (atTargetS && !newSel && blank_q == 3'h0) begin
                    state_d   = act_q.seqEnd ? ST_HOLD : ST_DWELL;
                    dwellLoad = !act_q.seqEnd;
                end
            end
            ST_DWELL: begin
                if (!running_d) begin
                    state_d = ST_IDLE;
                end else if (newSel) begin
                    state_d = ST_MOVE;
                end else if (dwellDone) begin
                    cur_d   = nextIdx;
                    state_d = ST_MOVE;
                end
            end
            ST_HOLD: begin
                if (!running_d) begin
                    state_d = ST_IDLE;
                end else if (newSel) begin
                    state_d = ST_MOVE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    tps_dwell #(.TICK(TICK)) uDwell (
        .clk   (clk),
        .rst_b (rst_b),
        .clkEn (clkEn),
        .load  (dwellLoad),
        .run   (state_q == ST_DWELL),
        .dwell (act_q.dwell),
        .done  (dwellDone)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= ST_IDLE;
            cur_q      <= SEL_RESET;
            running_q  <= 1'b0;
            direct_q   <= 1'b0;
            front_q    <= 1'b0;
            fieldbus_q <= 1'b0;
            strobeD_q  <= 1'b0;
            blank_q    <= 3'h0;
            act_q      <= tps_profile_s'(PROF_RESET);
        end else if (clkEn) begin
            state_q   <= state_d;
            cur_q     <= cur_d;
            running_q <= running_d;
            strobeD_q <= strobeS;
            if (wrCtrl) begin
                direct_q   <= hwdata[CTRL_DIRECT];
                front_q    <= hwdata[CTRL_FRONT];
                fieldbus_q <= hwdata[CTRL_FIELDBUS];
            end
            // The active copy latches only when a move begins, so edits never disturb it.
            if (state_d == ST_MOVE && (state_q != ST_MOVE || cur_d != cur_q)) begin
                act_q   <= prof_q[cur_d - 3'h1];
                blank_q <= 3'(ARRIVE_BLANK);
            end else if (blank_q != 3'h0) begin
                blank_q <= blank_q - 3'h1;
            end
        end
    end

    // ==========================================================
    // Outputs
    logic [POS_W-1:0]   tgt_q;
    logic [SPEED_W-1:0] cap_q;
    logic               drv_q;
    logic               sol_q;
    logic               inPos_q;
    wire                arrived = (state_q == ST_DWELL) || (state_q == ST_HOLD);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tgt_q   <= '0;
            cap_q   <= '0;
            drv_q   <= 1'b0;
            sol_q   <= 1'b0;
            inPos_q <= 1'b0;
        end else if (clkEn) begin
            tgt_q   <= act_q.pos;
            cap_q   <= act_q.speed;
            drv_q   <= (state_q != ST_IDLE);
            sol_q   <= (state_q == ST_MOVE) || (arrived && act_q.hold);
            inPos_q <= arrived && act_q.reached;
        end
    end

    assign targetPos      = tgt_q;
    assign currentCap     = cap_q;
    assign driveEnable    = drv_q;
    assign solenoidEnable = sol_q;
    assign inPosition     = inPos_q;

    // ==========================================================
    // Read data
    logic [31:0] rd_q;
    wire  [31:0] profWord = {curProf.hold, curProf.reached, curProf.seqEnd,
                             curProf.dwell, curProf.speed, curProf.pos};
    wire  [31:0] rdMux =
        (addr_q == ADDR_CTRL)   ? {27'h0, fieldbus_q, front_q, 2'b00, direct_q} :
        (addr_q == ADDR_STATUS) ? {24'h0, state_q, running_q, cur_q} :
        (addr_q == ADDR_SELECT) ? {29'h0, cur_q} :
        isProf(addr_q)          ? {prof_q[profIdx(addr_q)].hold,
                                   prof_q[profIdx(addr_q)].reached,
                                   prof_q[profIdx(addr_q)].seqEnd,
                                   prof_q[profIdx(addr_q)].dwell,
                                   prof_q[profIdx(addr_q)].speed,
                                   prof_q[profIdx(addr_q)].pos} : 32'h0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_q <= '0;
        end else if (clkEn) begin
            rd_q <= rdMux;
        end
    end

    // Data-phase read comes straight from the address captured last cycle.
    assign hrdata = rdPend_q ? rdMux : 32'h0;

    logic unusedOk;
    assign unusedOk = ^{rd_q, profWord, hsize, htrans[0], haddr[31:8]};
endmodule
`default_nettype wire

/* File: bench/tps_pos_model.sv */
// Behavioural position loop on the far side of the sequencer.
// Assumes targetPos and driveEnable are registered outputs of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module tps_pos_model
    import tps_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Sequencer side
    input  wire logic             driveEnable,
    input  wire logic [POS_W-1:0] targetPos,
    input  wire logic [7:0]       lat,
    output logic                  atTarget
);
    logic [POS_W-1:0] last_q;
    logic [7:0]       cnt_q;
    wire              moved = !driveEnable || (targetPos != last_q);
    // ==========================================================
    // Travel: the axis only gets there while it is driven, lat cycles after the last retarget.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_q   <= '0;
            cnt_q    <= 8'h00;
            atTarget <= 1'b0;
        end else begin
            last_q   <= targetPos;
            cnt_q    <= moved ? 8'h00 : (cnt_q == 8'hff ? cnt_q : cnt_q + 8'h01);
            atTarget <= !moved && (cnt_q >= lat);
        end
    end
endmodule
`default_nettype wire

/* File: bench/tps_monitor.sv */
// Checker of the sequencer's port behaviour.
// Assumes it is bound into tps_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tps_monitor
    import tps_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               clkEn,
    // Bus
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    input  wire logic [31:0]        hrdata,
    input  wire logic               hreadyout,
    input  wire logic               hresp,
    // Position loop
    input  wire logic               atTarget,
    input  wire logic [POS_W-1:0]   targetPos,
    input  wire logic [SPEED_W-1:0] currentCap,
    input  wire logic               driveEnable,
    input  wire logic               solenoidEnable,
    input  wire logic               inPosition
);
    logic       wrCtrl_q;
    logic       rdUnm_q;
    logic       ctrlDir_q;
    logic [3:0] atCnt_q;
    wire        addrPh = hsel && hready && htrans[1] && clkEn;
    wire        unmap  = (haddr[7:0] == 8'h0c) || (haddr[7:0] > ADDR_PROF_END);
    wire  [3:0] atCnt_d = !atTarget ? 4'h0 : (atCnt_q == 4'hf ? atCnt_q : atCnt_q + 4'h1);
    wire        ctlW   = wrCtrl_q && clkEn;
    // ==========================================================
    // Helper state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrCtrl_q  <= 1'b0;
            rdUnm_q   <= 1'b0;
            ctrlDir_q <= 1'b0;
            atCnt_q   <= 4'h0;
        end else begin
            wrCtrl_q  <= addrPh && hwrite && (haddr[7:0] == ADDR_CTRL);
            rdUnm_q   <= addrPh && !hwrite && unmap;
            ctrlDir_q <= ctlW ? hwdata[CTRL_DIRECT] : ctrlDir_q;
            atCnt_q   <= atCnt_d;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    unmapped_zero_a: assert property (rdUnm_q |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    cap_limit_a: assert property (currentCap <= SPEED_MAX) else $error("cap above 100");
    start_drive_a: assert property (ctlW && hwdata[CTRL_DIRECT] && hwdata[CTRL_START]
        && !hwdata[CTRL_STOP] |-> ##[1:3] driveEnable) else $error("start did not drive");
    stop_halt_a: assert property (ctlW && hwdata[CTRL_STOP] |-> ##[1:3] !driveEnable)
        else $error("stop did not halt");
    front_go_a: assert property (ctlW && hwdata[CTRL_DIRECT] && hwdata[CTRL_FRONT]
        && !hwdata[CTRL_STOP] |-> ##[1:3] driveEnable) else $error("front enable idle");
    tool_halt_a: assert property (ctlW && !ctrlDir_q && hwdata[CTRL_DIRECT]
        && !hwdata[CTRL_FRONT] && !hwdata[CTRL_START] |-> ##2 !driveEnable [*4])
        else $error("tool enable moved");
    reach_cause_a: assert property ($rose(inPosition) |-> atCnt_q >= 4'h2)
        else $error("in position without arrival");
    sol_drop_a: assert property ($fell(solenoidEnable) && driveEnable |-> atCnt_q >= 4'h2)
        else $error("solenoid off without arrival");
    idle_sol_a: assert property (!driveEnable |-> !solenoidEnable)
        else $error("solenoid on while idle");
    freeze_out_a: assert property (!clkEn |=> $stable(targetPos) && $stable(driveEnable))
        else $error("outputs moved while frozen");
    cover property (ctlW && hwdata[CTRL_START]);
    cover property ($rose(inPosition));
    cover property ($fell(driveEnable));
endmodule
bind tps_top tps_monitor #(.TICK(TICK)) mon_u (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .atTarget(atTarget), .targetPos(targetPos), .currentCap(currentCap),
    .driveEnable(driveEnable), .solenoidEnable(solenoidEnable), .inPosition(inPosition));
`default_nettype wire

/* File: bench/tps_testbench.sv */
// Self-checking bench of the travel profile sequencer.
// Assumes a fast dwell tick (TICK 10) and the position loop model on the far side.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import tps_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst_b, clkEn, hsel, hwrite, dinSelStrobe, rdPend;
    logic              hready, hreadyout, hresp, atTarget, driveEnable, solenoidEnable, inPosition;
    logic [31:0]       haddr, hwdata, hrdata, rngState, rnd;
    logic [31:0]       prof [0:6];
    logic [1:0]        htrans;
    logic [2:0]        hsize, dinSelect;
    logic [7:0]        lat;
    logic [POS_W-1:0]  targetPos;
    logic [SPEED_W-1:0] currentCap, spd;
    logic [63:0]       note;
    logic [63:0]       expQ [$];
    int                num_errors = 0;
    int                checks = 0;
    int                n;
    assign hready = hreadyout;
    always #10 clk = ~clk;
    tps_top #(.TICK(10)) dut_u (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .dinSelect(dinSelect), .dinSelStrobe(dinSelStrobe), .atTarget(atTarget),
        .targetPos(targetPos), .currentCap(currentCap), .driveEnable(driveEnable),
        .solenoidEnable(solenoidEnable), .inPosition(inPosition));
    tps_pos_model pos_u (.clk(clk), .rst_b(rst_b), .driveEnable(driveEnable),
        .targetPos(targetPos), .lat(lat), .atTarget(atTarget));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs();
        rngState = rngState ^ (rngState << 13);
        rngState = rngState ^ (rngState >> 17);
        rngState = rngState ^ (rngState << 5);
        return rngState;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic edgeReady();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 16);
        if (k >= 16) begin
            num_errors++;
            final_report();
        end
    endtask
    // Reads leave their expectation in the queue; the watcher below pairs it with hrdata.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic [31:0] m);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        edgeReady();
        htrans <= 2'b00;
        hwdata <= d;
        rdPend <= !w;
        if (!w) expQ.push_back({m, e & m});
        edgeReady();
        rdPend <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, xs(), e, m);
    endtask
    always @(posedge clk) begin
        if (rdPend && hreadyout && expQ.size() > 0) begin
            note = expQ.pop_front();
            chk(hrdata & note[63:32], note[31:0]);
        end
    end
    function automatic logic [31:0] cur(input int sel);
        case (sel)
            0: cur = {31'h0, driveEnable};
            1: cur = {31'h0, inPosition};
            default: cur = {17'h0, targetPos};
        endcase
    endfunction
    task automatic waitSig(input int sel, input logic [31:0] v, input int lim);
        n = 0;
        while (cur(sel) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            num_errors++;
            final_report();
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        rngState = 32'h6aca273f;
        {rst_b, clkEn, hsel, hwrite, dinSelStrobe, rdPend, htrans, hsize, dinSelect} = '0;
        haddr = '0;
        hwdata = '0;
        lat = 8'h03;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        clkEn <= 1'b1;
        @(posedge clk);
        rd(ADDR_STATUS, 32'h11, 32'hff);
        rd(ADDR_SELECT, {29'h0, SEL_RESET}, 32'h7);
        rd(ADDR_PROF0, PROF_RESET, 32'hffffffff);
        wr(8'h30, xs());
        rd(8'h30, 32'h0, 32'hffffffff);
        rd(8'h0c, 32'h0, 32'hffffffff);
        for (int i = 0; i < 7; i++) begin
            rnd = xs();
            spd = rnd[22:16];
            prof[i] = {i == 5, i == 5, i == 0, 7'((i == 5) ? 2 : (i == 6) ? 0 : 1), spd,
                       3'(i), rnd[11:0]};
            wr(ADDR_PROF0 + 8'(4 * i), prof[i]);
            if (spd > SPEED_MAX) prof[i][21:15] = SPEED_MAX;
            rd(ADDR_PROF0 + 8'(4 * i), prof[i], 32'hffffffff);
        end
        chk({31'h0, driveEnable}, 32'h0);
        $display("test store done");
        wr(ADDR_SELECT, 32'h6);
        wr(ADDR_SELECT, 32'h0);
        rd(ADDR_SELECT, 32'h6, 32'h7);
        wr(ADDR_CTRL, 32'h1);
        repeat (5) @(posedge clk);
        chk({31'h0, driveEnable}, 32'h0);
        rnd = xs();
        lat <= {5'h0, rnd[2:0]} + 8'h01;
        wr(ADDR_CTRL, 32'h3);
        waitSig(2, {17'h0, prof[5][14:0]}, 10);
        waitSig(1, 32'h1, 60);
        chk({31'h0, solenoidEnable}, 32'h1);
        waitSig(2, {17'h0, prof[6][14:0]}, 60);
        chk(32'(n >= 16 && n <= 24), 32'h1);
        waitSig(2, {17'h0, prof[0][14:0]}, 60);
        repeat (60) @(posedge clk);
        chk({17'h0, targetPos}, {17'h0, prof[0][14:0]});
        chk({30'h0, solenoidEnable, inPosition}, 32'h0);
        rd(ADDR_STATUS, 32'h80, 32'hf0);
        clkEn <= 1'b0;
        repeat (5) @(posedge clk);
        clkEn <= 1'b1;
        $display("test sequence done");
        wr(ADDR_SELECT, 32'h2);
        waitSig(2, {17'h0, prof[1][14:0]}, 20);
        wr(ADDR_CTRL, 32'h5);
        repeat (3) @(posedge clk);
        chk({30'h0, driveEnable, solenoidEnable}, 32'h0);
        $display("test reselect and stop done");
        wr(ADDR_CTRL, 32'h10);
        wr(ADDR_SELECT, 32'h4);
        rd(ADDR_SELECT, 32'h2, 32'h7);
        dinSelect <= 3'h5;
        repeat (3) @(posedge clk);
        dinSelStrobe <= 1'b1;
        repeat (4) @(posedge clk);
        dinSelStrobe <= 1'b0;
        repeat (4) @(posedge clk);
        rd(ADDR_SELECT, 32'h5, 32'h7);
        lat <= 8'h14;
        wr(ADDR_CTRL, 32'h19);
        waitSig(0, 32'h1, 6);
        waitSig(2, {17'h0, prof[4][14:0]}, 6);
        wr(ADDR_CTRL, 32'h5);
        repeat (3) @(posedge clk);
        $display("test fieldbus and front done");
        final_report();
    end
endmodule
`default_nettype wire
